// *** dcu_channel_ctrl.sv ***
// Functional notes
// - Reserved bits 31-21 read zero, software writes zero
// - Channel three bit 20 selects indirect source
// - Bit 20 absent, reads zero, elsewhere
// - End flag cleared only by 0 after read-1
// - Bit 19 selects channel two source reload
// - Bit 19 absent, reads zero, elsewhere
// - Reload select resets 0; 1 reloads source
`default_nettype none
module dcu_channel_ctrl
    import dcu_pkg::*;
(
    // Clock, reset, enable
    input wire logic refClk,
    input wire logic rst,
    input wire logic ce,
    // Register port
    input wire logic [dcu_pkg::ADDR_W-1:0] regAddr,
    input wire logic [dcu_pkg::DATA_W-1:0] wrData,
    input wire logic wrStb,
    input wire logic rdStb,
    output logic [dcu_pkg::DATA_W-1:0] rdData_q,
    // Transfer engine side
    input wire logic [dcu_pkg::NUM_CH-1:0] transferDone,
    output logic indirectSourceSelect_q,
    output logic sourceReloadSelect_q,
    output logic [dcu_pkg::NUM_CH-1:0] transferEndFlag_q,
    // Interrupt
    output logic irq_q
);
    import dcu_pkg::*;

    logic indirectSourceSelect_d;
    logic sourceReloadSelect_d;
    logic [NUM_CH-1:0] transferEndFlag_d;
    logic [NUM_CH-1:0] clearArmed_q;
    logic [NUM_CH-1:0] clearArmed_d;
    logic [NUM_CH-1:0] intStatus_q;
    logic [NUM_CH-1:0] intStatus_d;
    logic [NUM_CH-1:0] intEnable_q;
    logic [NUM_CH-1:0] intEnable_d;
    logic [DATA_W-1:0] rdData_d;
    logic irq_d;
    logic [NUM_CH-1:0] ctrlHit;

    // Decode of the per-channel control words
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
            assign ctrlHit[gi] =
                (regAddr == CTRL0_OFS + CTRL_STRIDE * 8'(gi));
            // Hardware set beats the software clear in the same cycle
            always_comb begin
                transferEndFlag_d[gi] = transferEndFlag_q[gi];
                clearArmed_d[gi] = clearArmed_q[gi];
                if (rdStb && ctrlHit[gi] && transferEndFlag_q[gi]) begin
                    clearArmed_d[gi] = 1'b1;
                end
                if (wrStb && ctrlHit[gi]) begin
                    if (clearArmed_q[gi] && !wrData[TE_POS]) begin
                        transferEndFlag_d[gi] = 1'b0;
                    end
                    clearArmed_d[gi] = 1'b0;
                end
                if (transferDone[gi]) begin
                    transferEndFlag_d[gi] = 1'b1;
                    clearArmed_d[gi] = 1'b0;
                end
            end
        end
    endgenerate

    // Optional select bits live only in their own channel
    always_comb begin
        indirectSourceSelect_d = indirectSourceSelect_q;
        sourceReloadSelect_d = sourceReloadSelect_q;
        if (wrStb && ctrlHit[INDIRECT_CH]) begin
            indirectSourceSelect_d = wrData[INDIRECT_POS];
        end
        if (wrStb && ctrlHit[RELOAD_CH]) begin
            sourceReloadSelect_d = wrData[RELOAD_POS];
        end
    end

    // Sticky status, write-one clear, set wins over clear
    always_comb begin
        intStatus_d = intStatus_q;
        intEnable_d = intEnable_q;
        if (wrStb && regAddr == INT_CLEAR_OFS) begin
            intStatus_d = intStatus_q & ~wrData[NUM_CH-1:0];
        end
        if (wrStb && regAddr == INT_ENABLE_OFS) begin
            intEnable_d = wrData[NUM_CH-1:0];
        end
        intStatus_d = intStatus_d | transferDone;
        // Registered, so the line trails the status by one cycle
        irq_d = |(intStatus_q & intEnable_q);
    end

    // Read data is valid only in the cycle after the strobe
    always_comb begin
        rdData_d = ZERO_WORD;
        if (rdStb) begin
            for (int ch = 0; ch < NUM_CH; ch++) begin
                if (ctrlHit[ch]) begin
                    rdData_d[TE_POS] = transferEndFlag_q[ch];
                end
            end
            if (ctrlHit[INDIRECT_CH]) begin
                rdData_d[INDIRECT_POS] = indirectSourceSelect_q;
            end
            if (ctrlHit[RELOAD_CH]) begin
                rdData_d[RELOAD_POS] = sourceReloadSelect_q;
            end
            if (regAddr == INT_STATUS_OFS) begin
                rdData_d[NUM_CH-1:0] = intStatus_q;
            end
            if (regAddr == INT_ENABLE_OFS) begin
                rdData_d[NUM_CH-1:0] = intEnable_q;
            end
        end
    end

    // State registers; clock enable freezes everything
    always_ff @(posedge refClk) begin
        if (rst) begin
            indirectSourceSelect_q <= 1'b0;
            sourceReloadSelect_q <= 1'b0;
            transferEndFlag_q <= ZERO_NIB;
            clearArmed_q <= ZERO_NIB;
            intStatus_q <= ZERO_NIB;
            intEnable_q <= ZERO_NIB;
            rdData_q <= ZERO_WORD;
            irq_q <= 1'b0;
        end else if (ce) begin
            indirectSourceSelect_q <= indirectSourceSelect_d;
            sourceReloadSelect_q <= sourceReloadSelect_d;
            transferEndFlag_q <= transferEndFlag_d;
            clearArmed_q <= clearArmed_d;
            intStatus_q <= intStatus_d;
            intEnable_q <= intEnable_d;
            rdData_q <= rdData_d;
            irq_q <= irq_d;
        end
    end

    // Checks
    reserved_read_a: assert property (
        @(posedge refClk) disable iff (rst)
        ce && rdStb |=> rdData_q[RSVD_HI_POS:RSVD_LO_POS] == 11'h000)
        else $error("reserved control bits read nonzero");

    indirect_write_a: assert property (
        @(posedge refClk) disable iff (rst)
        ce && wrStb && regAddr == CTRL3_OFS
        |=> indirectSourceSelect_q == $past(wrData[INDIRECT_POS]))
        else $error("indirect select did not take write");

    indirect_absent_a: assert property (
        @(posedge refClk) disable iff (rst)
        ce && !(wrStb && regAddr == CTRL3_OFS)
        |=> $stable(indirectSourceSelect_q) && !(rdData_q[INDIRECT_POS]
            && $past(rdStb && regAddr != CTRL3_OFS)))
        else $error("indirect select changed or leaked");

    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_chk
            // Reset is the only other way a flag may fall
            te_clear_a: assert property (
                @(posedge refClk) disable iff (rst)
                $fell(transferEndFlag_q[gi])
                |-> $past(rst)
                    || $past(ce && wrStb && ctrlHit[gi] && !wrData[TE_POS]
                    && clearArmed_q[gi]))
                else $error("end flag cleared without read-1 write-0");

            te_set_wins_a: assert property (
                @(posedge refClk) disable iff (rst)
                ce && transferDone[gi] |=> transferEndFlag_q[gi])
                else $error("end flag event lost");

            // Arming needs a read that saw the flag set
            arm_after_read_a: assert property (
                @(posedge refClk) disable iff (rst)
                $rose(clearArmed_q[gi]) |-> $past(ce && rdStb
                    && ctrlHit[gi] && transferEndFlag_q[gi]))
                else $error("clear armed without a read of one");
        end
    endgenerate

    reload_write_a: assert property (
        @(posedge refClk) disable iff (rst)
        ce && wrStb && regAddr == CTRL2_OFS
        |=> sourceReloadSelect_q == $past(wrData[RELOAD_POS]))
        else $error("reload select did not take write");

    reload_absent_a: assert property (
        @(posedge refClk) disable iff (rst)
        ce && rdStb && regAddr != CTRL2_OFS |=> !rdData_q[RELOAD_POS])
        else $error("reload bit read nonzero off channel two");

    reset_clear_a: assert property (
        @(posedge refClk)
        rst |=> !indirectSourceSelect_q && !sourceReloadSelect_q
            && transferEndFlag_q == 4'h0)
        else $error("control bits not cleared by reset");

    irq_level_a: assert property (
        @(posedge refClk) disable iff (rst)
        ce |=> irq_q == $past(|(intStatus_q & intEnable_q)))
        else $error("interrupt line does not follow status");

    read_idle_a: assert property (
        @(posedge refClk) disable iff (rst)
        ce && !rdStb |=> rdData_q == 32'h0000_0000)
        else $error("read data outside its cycle");

    // A low enable must hold the end flags, the irq line and both select bits, strobes and events alike
    freeze_hold_a: assert property (
        @(posedge refClk) disable iff (rst)
        !ce |=> $stable(transferEndFlag_q) && $stable(irq_q)
            && $stable(indirectSourceSelect_q)
            && $stable(sourceReloadSelect_q))
        else $error("state moved while enable was low");
endmodule : dcu_channel_ctrl
`default_nettype wire

// *** dcu_pkg.sv ***
`default_nettype none
package dcu_pkg;
    // Geometry
    localparam int NUM_CH = 4;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // Register byte offsets
    localparam logic [7:0] CTRL0_OFS = 8'h00;
    localparam logic [7:0] CTRL1_OFS = 8'h04;
    localparam logic [7:0] CTRL2_OFS = 8'h08;
    localparam logic [7:0] CTRL3_OFS = 8'h0C;
    localparam logic [7:0] INT_STATUS_OFS = 8'h10;
    localparam logic [7:0] INT_CLEAR_OFS = 8'h14;
    localparam logic [7:0] INT_ENABLE_OFS = 8'h18;
    localparam logic [7:0] CTRL_STRIDE = 8'h04;
    // Control register field positions
    localparam int RSVD_HI_POS = 31;
    localparam int RSVD_LO_POS = 21;
    localparam int INDIRECT_POS = 20;
    localparam int RELOAD_POS = 19;
    localparam int TE_POS = 0;
    // Channels that own the optional bits
    localparam int INDIRECT_CH = 3;
    localparam int RELOAD_CH = 2;
    // Reset values
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [3:0] ZERO_NIB = 4'h0;
endpackage : dcu_pkg
`default_nettype wire

// *** dma_channel_control_upper_tb.sv ***
`default_nettype none
module dma_channel_control_upper_tb
    import dcu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] ONE = 32'h0000_0001;
    // Stimulus and observed signals
    logic refClk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [ADDR_W-1:0] regAddr = 8'h00;
    logic [DATA_W-1:0] wrData = 32'h0000_0000;
    logic wrStb = 1'b0;
    logic rdStb = 1'b0;
    logic [NUM_CH-1:0] transferDone = 4'h0;
    logic [DATA_W-1:0] rdData_q;
    logic indirectSourceSelect_q;
    logic sourceReloadSelect_q;
    logic [NUM_CH-1:0] transferEndFlag_q;
    logic irq_q;
    int badCount = 0;
    int samplesChecked = 0;
    dcu_channel_ctrl i_dut (.refClk(refClk), .rst(rst), .ce(ce),
        .regAddr(regAddr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
        .rdData_q(rdData_q), .transferDone(transferDone),
        .indirectSourceSelect_q(indirectSourceSelect_q),
        .sourceReloadSelect_q(sourceReloadSelect_q),
        .transferEndFlag_q(transferEndFlag_q), .irq_q(irq_q));
    // 40 MHz clock
    initial begin
        forever #12.5 refClk = ~refClk;
    end
    task automatic finishTest();
        if (badCount == 0 && samplesChecked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finishTest
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            badCount++;
        end
    endtask : chk
    // Strobe tasks wait an edge first, so back-to-back calls never collide
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge refClk);
        regAddr <= a;
        wrData <= d;
        wrStb <= 1'b1;
        @(posedge refClk);
        wrStb <= 1'b0;
        // Let the edge that took the write settle before any compare
        #1;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge refClk);
        regAddr <= a;
        rdStb <= 1'b1;
        @(posedge refClk);
        rdStb <= 1'b0;
        #1;
        chk(rdData_q, exp);
    endtask : rd
    task automatic done(input logic [3:0] v);
        @(posedge refClk);
        transferDone <= v;
        @(posedge refClk);
        transferDone <= 4'h0;
        #1;
    endtask : done
    // Hang guard
    initial begin
        repeat (5000) @(posedge refClk);
        badCount++;
        finishTest();
    end
    initial begin
        repeat (20) @(posedge refClk);
        rst <= 1'b0;
        // Reset state of every readable place, unmapped one included
        for (int i = 0; i < 8; i++) begin
            if (i != 5) rd(8'(i * 4), ZERO_WORD);
        end
        // Ones in the four control words and the unmapped place, reserved bits kept at zero
        for (int i = 0; i < 4; i++) wr(8'(i * 4), 32'h001F_FFFF);
        wr(8'h1C, 32'h001F_FFFF);
        for (int i = 0; i < 4; i++) begin
            rd(8'(i * 4),
                ((i == RELOAD_CH) ? ONE << RELOAD_POS : ZERO_WORD)
                | ((i == INDIRECT_CH) ? ONE << INDIRECT_POS : ZERO_WORD)
            );
        end
        rd(8'h1C, ZERO_WORD);
        chk(indirectSourceSelect_q, ONE);
        chk(sourceReloadSelect_q, ONE);
        chk(transferEndFlag_q, ZERO_WORD);
        wr(CTRL3_OFS, ZERO_WORD);
        wr(CTRL2_OFS, ZERO_WORD);
        chk(indirectSourceSelect_q, ZERO_WORD);
        chk(sourceReloadSelect_q, ZERO_WORD);
        // End events on channels 0 and 1, only channel 1 enabled
        wr(INT_ENABLE_OFS, 32'h0000_0002);
        done(4'h3);
        chk(transferEndFlag_q, 32'h0000_0003);
        @(posedge refClk);
        #1;
        chk(irq_q, ONE);
        // Clear without a prior read, and a write of one, both refused
        wr(CTRL1_OFS, ZERO_WORD);
        chk(transferEndFlag_q, 32'h0000_0003);
        rd(CTRL1_OFS, ONE);
        wr(CTRL1_OFS, ONE);
        wr(CTRL1_OFS, ZERO_WORD);
        chk(transferEndFlag_q, 32'h0000_0003);
        rd(CTRL1_OFS, ONE);
        wr(CTRL1_OFS, ZERO_WORD);
        chk(transferEndFlag_q, ONE);
        chk(irq_q, ONE);
        // Status clear, then masking and enabling
        wr(INT_CLEAR_OFS, 32'h0000_0002);
        rd(INT_STATUS_OFS, ONE);
        chk(irq_q, ZERO_WORD);
        wr(INT_ENABLE_OFS, 32'h0000_0003);
        @(posedge refClk);
        #1;
        chk(irq_q, ONE);
        // Second reset in mid-run with the optional bits set
        // Indirect mode: the source pointer holds the data's location
        wr(CTRL3_OFS, ONE << INDIRECT_POS);
        wr(CTRL2_OFS, ONE << RELOAD_POS);
        chk({indirectSourceSelect_q, sourceReloadSelect_q}, 32'h3);
        @(posedge refClk);
        rst <= 1'b1;
        repeat (2) @(posedge refClk);
        rst <= 1'b0;
        #1;
        chk({indirectSourceSelect_q, sourceReloadSelect_q}, ZERO_WORD);
        chk({transferEndFlag_q, irq_q}, ZERO_WORD);
        rd(CTRL3_OFS, ZERO_WORD);
        rd(CTRL2_OFS, ZERO_WORD);
        rd(INT_ENABLE_OFS, ZERO_WORD);
        // Enable low: a write and an end event are both ignored
        @(posedge refClk);
        ce <= 1'b0;
        wr(CTRL3_OFS, ONE << INDIRECT_POS);
        done(4'h4);
        @(posedge refClk);
        ce <= 1'b1;
        #1;
        chk(indirectSourceSelect_q, ZERO_WORD);
        chk(transferEndFlag_q, ZERO_WORD);
        // Event and armed clear in one cycle: set wins and disarms
        done(4'h1);
        rd(CTRL0_OFS, ONE);
        @(posedge refClk);
        regAddr <= CTRL0_OFS;
        wrData <= ZERO_WORD;
        wrStb <= 1'b1;
        transferDone <= 4'h1;
        @(posedge refClk);
        wrStb <= 1'b0;
        transferDone <= 4'h0;
        #1;
        chk(transferEndFlag_q, ONE);
        wr(CTRL0_OFS, ZERO_WORD);
        chk(transferEndFlag_q, ONE);
        finishTest();
    end
endmodule : dma_channel_control_upper_tb
`default_nettype wire
